// File: hw/sensor_ctl_pkg.sv
// Shared constants for the sensor reset and reload controller.
package sensor_ctl_pkg;
	// =====================================================================
	// Register map
	localparam logic [7:0] ADDR_INTERFACE_SELECT = 8'h0D;
	localparam logic [7:0] ADDR_INIT_SETTING_A = 8'h0F;
	localparam logic [7:0] ADDR_MODE_CONTROL = 8'h10;
	localparam logic [7:0] ADDR_INIT_SETTING_B = 8'h1A;
	localparam logic [7:0] ADDR_INIT_SETTING_C = 8'h20;
	localparam logic [7:0] ADDR_INIT_SETTING_D = 8'h21;
	localparam logic [7:0] ADDR_RESET_RELOAD_COMMAND = 8'h24;
	localparam logic [7:0] ADDR_INIT_SETTING_E = 8'h28;
	localparam logic [7:0] ADDR_RANGE_CONTROL = 8'h15;
	localparam logic [7:0] ADDR_X_SAMPLE_OUT = 8'h02;
	localparam logic [7:0] ADDR_Y_SAMPLE_OUT = 8'h03;
	localparam logic [7:0] ADDR_Z_SAMPLE_OUT = 8'h04;
	localparam logic [7:0] ADDR_FIFO_WATERMARK = 8'h16;
	localparam logic [7:0] ADDR_FIFO_LEVEL = 8'h17;
	localparam logic [7:0] ADDR_OFFSET_CAL = 8'h30;
	localparam logic [7:0] ADDR_GAIN_CAL = 8'h31;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	// =====================================================================
	// Fields
	localparam int BIT_SOFT_RESET = 6;
	localparam int BIT_RELOAD = 7;
	localparam int BIT_SEL_I2C = 6;
	localparam int BIT_SEL_SPI4 = 7;
	localparam int BIT_SEL_SPI3 = 5;
	localparam int BIT_TRIG_SAMPLE = 7;
	localparam int BIT_CLK_HEARTBEAT = 3;
	localparam logic [2:0] MODE_STANDBY = 3'h1;
	localparam logic [2:0] MODE_CWAKE = 3'h5;
	// =====================================================================
	// Reset values and sequence data
	localparam logic [7:0] RST_MODE_CONTROL = 8'h00;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] VAL_STANDBY = 8'h01;
	localparam logic [7:0] VAL_RESET_CMD = 8'h40;
	localparam logic [7:0] VAL_SEL_SPI = 8'h80;
	localparam logic [7:0] VAL_SEL_I2C = 8'h40;
	localparam logic [7:0] VAL_INIT_A = 8'h42;
	localparam logic [7:0] VAL_INIT_C = 8'h01;
	localparam logic [7:0] VAL_INIT_D = 8'h80;
	localparam logic [7:0] VAL_INIT_E = 8'h00;
	localparam logic [7:0] VAL_INIT_B = 8'h00;
	localparam logic [6:0] I2C_ADDR_LOW = 7'h4C;
	localparam logic [6:0] I2C_ADDR_HIGH = 7'h6C;
	// =====================================================================
	// Timing and FIFO sizes
	localparam int CLK_MHZ = 250;
	localparam int RESET_WAIT_US = 1000;
	localparam int RESET_WAIT_CYC = RESET_WAIT_US * CLK_MHZ;
	localparam int FIFO_WIDTH = 12;
	localparam int FIFO_DEPTH = 32;
endpackage

// File: hw/sensor_init_host.sv
// Host end: runs the standby, reset, wait and initialization sequence.
module sensor_init_host #(
	parameter int WAIT_CYC = sensor_ctl_pkg::RESET_WAIT_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	sensor_link_if.host link,
	input wire logic i_start,
	input wire logic i_use_spi,
	input wire logic i_strap,
	output logic o_done,
	output logic o_busy
);
	import sensor_ctl_pkg::*;

	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_WRITE = 2'b01,
		H_WAIT = 2'b10,
		H_DONE = 2'b11
	} host_e;

	host_e state_r, state_nxt;
	logic [3:0] step_r, step_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic spi_r, spi_nxt, wr_r, wr_nxt;
	logic [7:0] addr_r, addr_nxt, data_r, data_nxt;
	logic [7:0] sa, sd;

	// =====================================================================
	// Sequence table
	always_comb begin
		sa = ADDR_MODE_CONTROL;
		sd = VAL_STANDBY;
		case (step_r)
			4'h0: begin
				sa = ADDR_MODE_CONTROL;
				sd = VAL_STANDBY;
			end
			4'h1: begin
				sa = ADDR_RESET_RELOAD_COMMAND;
				sd = VAL_RESET_CMD;
			end
			4'h2: begin
				sa = ADDR_INTERFACE_SELECT;
				sd = spi_r ? VAL_SEL_SPI : VAL_SEL_I2C;
			end
			4'h3: begin
				sa = ADDR_INIT_SETTING_A;
				sd = VAL_INIT_A;
			end
			4'h4: begin
				sa = ADDR_INIT_SETTING_C;
				sd = VAL_INIT_C;
			end
			4'h5: begin
				sa = ADDR_INIT_SETTING_D;
				sd = VAL_INIT_D;
			end
			4'h6: begin
				sa = ADDR_INIT_SETTING_E;
				sd = VAL_INIT_E;
			end
			4'h7: begin
				sa = ADDR_INIT_SETTING_B;
				sd = VAL_INIT_B;
			end
			default: ;
		endcase
	end

	always_comb begin
		state_nxt = state_r;
		step_nxt = step_r;
		cnt_nxt = cnt_r;
		spi_nxt = spi_r;
		wr_nxt = 1'b0;
		addr_nxt = addr_r;
		data_nxt = data_r;
		case (state_r)
			H_IDLE: begin
				if (i_start) begin
					spi_nxt = i_use_spi;
					step_nxt = 4'h0;
					state_nxt = H_WRITE;
				end
			end
			H_WRITE: begin
				wr_nxt = 1'b1;
				addr_nxt = sa;
				data_nxt = sd;
				step_nxt = step_r + 4'h1;
				if (step_r == 4'h1) begin
					cnt_nxt = 32'(WAIT_CYC);
					state_nxt = H_WAIT;
				end else if (step_r == 4'h7) begin
					state_nxt = H_DONE;
				end
			end
			H_WAIT: begin
				if (cnt_r == 32'h0) begin
					state_nxt = H_WRITE;
				end else begin
					cnt_nxt = cnt_r - 32'h1;
				end
			end
			H_DONE: begin
				if (i_start) begin
					spi_nxt = i_use_spi;
					step_nxt = 4'h0;
					state_nxt = H_WRITE;
				end
			end
			default: state_nxt = H_IDLE;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state_r <= H_IDLE;
			step_r <= 4'h0;
			cnt_r <= 32'h0;
			spi_r <= 1'b0;
			wr_r <= 1'b0;
			addr_r <= 8'h00;
			data_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			step_r <= step_nxt;
			cnt_r <= cnt_nxt;
			spi_r <= spi_nxt;
			wr_r <= wr_nxt;
			addr_r <= addr_nxt;
			data_r <= data_nxt;
		end
	end

	assign link.wr = wr_r;
	assign link.rd = 1'b0;
	assign link.addr = addr_r;
	assign link.wdata = data_r;
	assign link.spi_select_n = !(spi_r && state_r != H_IDLE);
	assign link.addr_strap_pin = i_strap;
	assign o_done = (state_r == H_DONE);
	assign o_busy = (state_r == H_WRITE) || (state_r == H_WAIT);
endmodule

// File: hw/sensor_link_if.sv
// Register access link between the host controller and the sensor.
interface sensor_link_if;
	logic wr;
	logic rd;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic spi_select_n;
	logic addr_strap_pin;
	modport device(input wr, input rd, input addr, input wdata, output rdata,
		input spi_select_n, input addr_strap_pin);
	modport host(output wr, output rd, output addr, output wdata, input rdata,
		output spi_select_n, output addr_strap_pin);
endinterface

// File: hw/sensor_reset_reload_control.sv
// Sensor end: registers, full reset, reload, strap address, sample store and FIFO.
//
// The strobed register port is this design's own decision.
module sensor_reset_reload_control #(
	parameter int WAIT_CYC = sensor_ctl_pkg::RESET_WAIT_CYC,
	parameter logic [7:0] OTP_OFFSET_CAL = 8'h00,
	parameter logic [7:0] OTP_GAIN_CAL = 8'h80,
	parameter logic [7:0] OTP_RANGE = 8'h00
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	sensor_link_if.device link,
	input wire logic i_sample_valid,
	input wire logic signed [sensor_ctl_pkg::FIFO_WIDTH-1:0] i_x_sample,
	input wire logic signed [sensor_ctl_pkg::FIFO_WIDTH-1:0] i_y_sample,
	input wire logic signed [sensor_ctl_pkg::FIFO_WIDTH-1:0] i_z_sample,
	output logic [6:0] o_i2c_addr,
	output logic o_spi_mode,
	output logic o_busy,
	output logic o_heartbeat_clk,
	output logic o_trig_sample,
	output logic [7:0] o_range
);
	import sensor_ctl_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RESET = 2'b01,
		ST_RELOAD = 2'b10
	} seq_e;

	seq_e state_r, state_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic [7:0] ifsel_r, ifsel_nxt, init_a_r, init_a_nxt, mode_r, mode_nxt;
	logic [7:0] init_b_r, init_b_nxt, init_c_r, init_c_nxt, init_d_r, init_d_nxt;
	logic [7:0] init_e_r, init_e_nxt, range_r, range_nxt, wm_r, wm_nxt;
	logic [7:0] offs_r, offs_nxt, gain_r, gain_nxt, rdata_r, rdata_nxt;
	logic [6:0] i2c_addr_r, i2c_addr_nxt;
	logic spi_r, spi_nxt, trig_r, trig_nxt;
	logic [FIFO_WIDTH-1:0] x_r, x_nxt, y_r, y_nxt, z_r, z_nxt;
	logic [FIFO_WIDTH-1:0] fifo_mem [FIFO_DEPTH];
	logic [4:0] wp_r, wp_nxt;
	logic [5:0] lvl_r, lvl_nxt;
	logic acc;

	function automatic logic [6:0] strap_addr(input logic strap);
		return strap ? I2C_ADDR_HIGH : I2C_ADDR_LOW;
	endfunction

	// =====================================================================
	// Sequencer and register file
	assign acc = (link.wr || link.rd) && (state_r == ST_IDLE);

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		ifsel_nxt = ifsel_r;
		init_a_nxt = init_a_r;
		mode_nxt = mode_r;
		init_b_nxt = init_b_r;
		init_c_nxt = init_c_r;
		init_d_nxt = init_d_r;
		init_e_nxt = init_e_r;
		range_nxt = range_r;
		wm_nxt = wm_r;
		offs_nxt = offs_r;
		gain_nxt = gain_r;
		i2c_addr_nxt = i2c_addr_r;
		spi_nxt = spi_r;
		trig_nxt = 1'b0;
		rdata_nxt = RST_ZERO;
		if (state_r == ST_IDLE && !link.spi_select_n) begin
			spi_nxt = 1'b1;
		end
		case (state_r)
			ST_IDLE: begin
				if (link.wr) begin
					case (link.addr)
						ADDR_INTERFACE_SELECT: begin
							ifsel_nxt = link.wdata;
							spi_nxt = link.wdata[BIT_SEL_SPI4] | link.wdata[BIT_SEL_SPI3];
						end
						ADDR_INIT_SETTING_A: init_a_nxt = link.wdata;
						ADDR_MODE_CONTROL: begin
							mode_nxt = link.wdata;
							trig_nxt = link.wdata[BIT_TRIG_SAMPLE];
						end
						ADDR_INIT_SETTING_B: init_b_nxt = link.wdata;
						ADDR_INIT_SETTING_C: init_c_nxt = link.wdata;
						ADDR_INIT_SETTING_D: init_d_nxt = link.wdata;
						ADDR_INIT_SETTING_E: init_e_nxt = link.wdata;
						ADDR_RANGE_CONTROL: range_nxt = link.wdata;
						ADDR_FIFO_WATERMARK: wm_nxt = link.wdata;
						ADDR_RESET_RELOAD_COMMAND: begin
							cnt_nxt = 32'(WAIT_CYC - 1);
							if (link.wdata[BIT_RELOAD]) begin
								state_nxt = ST_RELOAD;
							end else if (link.wdata[BIT_SOFT_RESET]) begin
								state_nxt = ST_RESET;
							end
						end
						default: ;
					endcase
				end
				if (link.rd) begin
					case (link.addr)
						ADDR_INTERFACE_SELECT: rdata_nxt = ifsel_r;
						ADDR_INIT_SETTING_A: rdata_nxt = init_a_r;
						ADDR_MODE_CONTROL: rdata_nxt = mode_r;
						ADDR_INIT_SETTING_B: rdata_nxt = init_b_r;
						ADDR_INIT_SETTING_C: rdata_nxt = init_c_r;
						ADDR_INIT_SETTING_D: rdata_nxt = init_d_r;
						ADDR_INIT_SETTING_E: rdata_nxt = init_e_r;
						ADDR_RANGE_CONTROL: rdata_nxt = range_r;
						ADDR_FIFO_WATERMARK: rdata_nxt = wm_r;
						ADDR_FIFO_LEVEL: rdata_nxt = {2'h0, lvl_r};
						ADDR_X_SAMPLE_OUT: rdata_nxt = x_r[FIFO_WIDTH-1:FIFO_WIDTH-8];
						ADDR_Y_SAMPLE_OUT: rdata_nxt = y_r[FIFO_WIDTH-1:FIFO_WIDTH-8];
						ADDR_Z_SAMPLE_OUT: rdata_nxt = z_r[FIFO_WIDTH-1:FIFO_WIDTH-8];
						ADDR_OFFSET_CAL: rdata_nxt = offs_r;
						ADDR_GAIN_CAL: rdata_nxt = gain_r;
						ADDR_STATUS: rdata_nxt = {i2c_addr_r, spi_r};
						default: rdata_nxt = RST_ZERO;
					endcase
				end
			end
			ST_RESET, ST_RELOAD: begin
				if (cnt_r == 32'h0) begin
					state_nxt = ST_IDLE;
					i2c_addr_nxt = strap_addr(link.addr_strap_pin);
					offs_nxt = OTP_OFFSET_CAL;
					gain_nxt = OTP_GAIN_CAL;
					range_nxt = OTP_RANGE;
					if (state_r == ST_RESET) begin
						ifsel_nxt = RST_ZERO;
						init_a_nxt = RST_ZERO;
						mode_nxt = RST_MODE_CONTROL;
						init_b_nxt = RST_ZERO;
						init_c_nxt = RST_ZERO;
						init_d_nxt = RST_ZERO;
						init_e_nxt = RST_ZERO;
						wm_nxt = RST_ZERO;
						spi_nxt = 1'b0;
					end
				end else begin
					cnt_nxt = cnt_r - 32'h1;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	// =====================================================================
	// Sample store and FIFO
	always_comb begin
		x_nxt = x_r;
		y_nxt = y_r;
		z_nxt = z_r;
		wp_nxt = wp_r;
		lvl_nxt = lvl_r;
		if (state_r == ST_RESET && cnt_r == 32'h0) begin
			lvl_nxt = 6'h0;
			wp_nxt = 5'h0;
		end else if (i_sample_valid && mode_r[2:0] != MODE_STANDBY) begin
			x_nxt = i_x_sample;
			y_nxt = i_y_sample;
			z_nxt = i_z_sample;
			wp_nxt = wp_r + 5'h1;
			if (lvl_r != 6'(FIFO_DEPTH)) begin
				lvl_nxt = lvl_r + 6'h1;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sample_valid && mode_r[2:0] != MODE_STANDBY) begin
			fifo_mem[wp_r] <= i_x_sample;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state_r <= ST_IDLE;
			cnt_r <= 32'h0;
			ifsel_r <= RST_ZERO;
			init_a_r <= RST_ZERO;
			mode_r <= RST_MODE_CONTROL;
			init_b_r <= RST_ZERO;
			init_c_r <= RST_ZERO;
			init_d_r <= RST_ZERO;
			init_e_r <= RST_ZERO;
			range_r <= OTP_RANGE;
			wm_r <= RST_ZERO;
			offs_r <= OTP_OFFSET_CAL;
			gain_r <= OTP_GAIN_CAL;
			rdata_r <= RST_ZERO;
			i2c_addr_r <= I2C_ADDR_LOW;
			spi_r <= 1'b0;
			trig_r <= 1'b0;
			x_r <= '0;
			y_r <= '0;
			z_r <= '0;
			wp_r <= 5'h0;
			lvl_r <= 6'h0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			ifsel_r <= ifsel_nxt;
			init_a_r <= init_a_nxt;
			mode_r <= mode_nxt;
			init_b_r <= init_b_nxt;
			init_c_r <= init_c_nxt;
			init_d_r <= init_d_nxt;
			init_e_r <= init_e_nxt;
			range_r <= range_nxt;
			wm_r <= wm_nxt;
			offs_r <= offs_nxt;
			gain_r <= gain_nxt;
			rdata_r <= rdata_nxt;
			i2c_addr_r <= i2c_addr_nxt;
			spi_r <= spi_nxt;
			trig_r <= trig_nxt;
			x_r <= x_nxt;
			y_r <= y_nxt;
			z_r <= z_nxt;
			wp_r <= wp_nxt;
			lvl_r <= lvl_nxt;
		end
	end

	assign link.rdata = rdata_r;
	assign o_i2c_addr = i2c_addr_r;
	assign o_spi_mode = spi_r;
	assign o_busy = (state_r != ST_IDLE) && !acc;
	assign o_heartbeat_clk = mode_r[BIT_CLK_HEARTBEAT];
	assign o_trig_sample = trig_r;
	assign o_range = range_r;
endmodule

// File: sim/sensor_link_assertions.sv
// Checker for the register link between the host end and the sensor end.
module sensor_link_assertions #(
	parameter int WAIT_CYC = 20
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic wr,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// =====================================================
	// Helper state
	logic cmd;
	logic [31:0] quiet_r;
	logic stby_r;
	logic sel_pend_r;
	assign cmd = wr && addr == 8'h24;
	// Counts cycles since the last command write, saturating.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			quiet_r <= 32'hFFFF;
			stby_r <= 1'b0;
			sel_pend_r <= 1'b0;
		end else begin
			quiet_r <= cmd ? 32'h0 : quiet_r + {31'h0, quiet_r < 32'hFFFF};
			if (wr && addr == 8'h10) stby_r <= wdata[2:0] == 3'h1;
			if (wr) sel_pend_r <= cmd;
		end
	end
	// =====================================================
	// Properties
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence sel_w;
		wr && addr == 8'h0D;
	endsequence
	sequence init_s;
		(wr && addr == 8'h0F && wdata == 8'h42) ##1 (wr && addr == 8'h20 && wdata == 8'h01)
		##1 (wr && addr == 8'h21 && wdata == 8'h80) ##1 (wr && addr == 8'h28 && wdata == 8'h00)
		##1 (wr && addr == 8'h1A && wdata == 8'h00);
	endsequence
	reset_quiet_a: assert property (wr && !cmd |-> quiet_r >= WAIT_CYC)
		else $error("access inside the reset wait");
	standby_first_a: assert property (cmd |-> stby_r)
		else $error("command written outside standby");
	standby_reset_a: assert property (wr && addr == 8'h10 && wdata == 8'h01 |=> cmd)
		else $error("standby not followed by reset command");
	reset_value_a: assert property (cmd |-> wdata == 8'h40)
		else $error("wrong reset command value");
	sel_first_a: assert property (wr && sel_pend_r |-> addr == 8'h0D)
		else $error("first access after reset is not the select");
	sel_value_a: assert property (sel_w |-> wdata == 8'h80 || wdata == 8'h40)
		else $error("bad interface select value");
	sel_onehot_a: assert property (sel_w |-> $onehot(wdata[7:5]))
		else $error("interface select not one hot");
	init_order_a: assert property (sel_w |=> init_s)
		else $error("initialization writes out of order");
	init_seen_c: cover property (sel_w ##1 init_s);
endmodule

// File: sim/testbench.sv
// Testbench joining the host and sensor ends across the register link.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import sensor_ctl_pkg::*;
	// =====================================================
	// Signals
	localparam int W = 20;
	// Store contents for the directly driven sensor; the values are arbitrary.
	localparam logic [7:0] OFFS_OTP = 8'h5A;
	localparam logic [7:0] GAIN_OTP = 8'hA7;
	localparam logic [7:0] RANGE_OTP = 8'h21;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic start = 1'b0;
	logic use_spi = 1'b0;
	logic strap = 1'b0;
	logic smp_valid = 1'b0;
	logic signed [FIFO_WIDTH-1:0] xs = '0;
	logic signed [FIFO_WIDTH-1:0] ys = '0;
	logic signed [FIFO_WIDTH-1:0] zs = '0;
	logic [6:0] i2c_addr;
	logic spi_mode;
	logic dev_busy;
	logic done;
	logic [63:0] rnd;
	logic [15:0] obs[$];
	logic [15:0] exp_w[8];
	int seed = 91611;
	int n_fail = 0;
	int total_checks = 0;
	int cyc = 0;
	int t24 = 0;
	int gap = 0;
	int busy_n = 0;
	int mlvl = 0;
	int mrst = 0;
	logic [2:0] mmode = 3'h0;
	logic [FIFO_WIDTH-1:0] mx;
	logic [FIFO_WIDTH-1:0] my;
	logic [FIFO_WIDTH-1:0] mz;
	logic [6:0] d_addr;
	logic d_spi;
	logic d_busy;
	logic d_hb;
	logic d_trig;
	logic [7:0] d_range;
	logic h_busy;
	sensor_link_if lnk();
	sensor_link_if lnk2();
	sensor_reset_reload_control #(.WAIT_CYC(W)) i_sensor_reset_reload_control (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .link(lnk.device), .i_sample_valid(smp_valid),
		.i_x_sample(xs), .i_y_sample(ys), .i_z_sample(zs), .o_i2c_addr(i2c_addr),
		.o_spi_mode(spi_mode), .o_busy(dev_busy), .o_heartbeat_clk(), .o_trig_sample(),
		.o_range());
	sensor_init_host #(.WAIT_CYC(W)) i_sensor_init_host (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .link(lnk.host), .i_start(start),
		.i_use_spi(use_spi), .i_strap(strap), .o_done(done), .o_busy(h_busy));
	// A second sensor driven straight from the bench reaches reads, reload and samples.
	if (1) begin : g_direct
		sensor_reset_reload_control #(.WAIT_CYC(W), .OTP_OFFSET_CAL(OFFS_OTP),
			.OTP_GAIN_CAL(GAIN_OTP), .OTP_RANGE(RANGE_OTP)) i_sensor_reset_reload_control (
			.i_clk(i_clk), .i_rst_n(i_rst_n), .link(lnk2.device), .i_sample_valid(smp_valid),
			.i_x_sample(xs), .i_y_sample(ys), .i_z_sample(zs), .o_i2c_addr(d_addr),
			.o_spi_mode(d_spi), .o_busy(d_busy), .o_heartbeat_clk(d_hb), .o_trig_sample(d_trig),
			.o_range(d_range));
	end
	sensor_link_assertions #(.WAIT_CYC(W)) i_sensor_link_assertions (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .wr(lnk.wr), .addr(lnk.addr), .wdata(lnk.wdata));
	always #2 i_clk = ~i_clk;
	// =====================================================
	// Monitor and random sample traffic
	always @(posedge i_clk) begin
		cyc++;
		rnd = {$random(seed), $random(seed)};
		smp_valid <= rnd[36];
		{xs, ys, zs} <= rnd[35:0];
		if (!i_rst_n) begin
			obs.delete();
		end else if (lnk.wr === 1'b1) begin
			obs.push_back({lnk.addr, lnk.wdata});
			if (lnk.addr === 8'h24) t24 = cyc;
			if (lnk.addr === 8'h0D) gap = cyc - t24;
		end
		if (dev_busy === 1'b1) busy_n++;
	end
	// Integer model of the second sensor's sample store, level count and reset end.
	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			mmode = RST_MODE_CONTROL[2:0];
			mlvl = 0;
			mrst = 0;
			mx = '0;
			my = '0;
			mz = '0;
		end else begin
			if (smp_valid === 1'b1 && mmode != MODE_STANDBY) begin
				mx = xs;
				my = ys;
				mz = zs;
				if (mlvl < FIFO_DEPTH) mlvl++;
			end
			if (mrst > 0) begin
				mrst--;
				if (mrst == 0) begin
					mmode = RST_MODE_CONTROL[2:0];
					mlvl = 0;
				end
			end
			if (lnk2.wr === 1'b1 && lnk2.addr === ADDR_MODE_CONTROL) mmode = lnk2.wdata[2:0];
			if (lnk2.wr === 1'b1 && lnk2.addr === ADDR_RESET_RELOAD_COMMAND &&
				lnk2.wdata[7:6] === 2'b01) mrst = W;
		end
	end
	// =====================================================
	// Tasks
	task automatic results();
		if (n_fail == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic c, input string m);
		total_checks++;
		if (c !== 1'b1) begin
			n_fail++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	// Register port master: each call starts just after a rising edge and ends on one.
	task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
		lnk2.wr <= 1'b1;
		lnk2.addr <= a;
		lnk2.wdata <= d;
		@(posedge i_clk);
		lnk2.wr <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic bus_rd(input logic [7:0] a, input logic [7:0] e);
		lnk2.rd <= 1'b1;
		lnk2.addr <= a;
		@(posedge i_clk);
		lnk2.rd <= 1'b0;
		@(posedge i_clk);
		check(lnk2.rdata === e, "register read differs");
		@(posedge i_clk);
		check(lnk2.rdata === 8'h00, "read data held too long");
	endtask
	task automatic direct();
		logic [31:0] v;
		v = $random(seed);
		v[0] = 1'b1;
		v[16] = 1'b1;
		v[15] = ~RANGE_OTP[7];
		bus_rd(ADDR_GAIN_CAL, GAIN_OTP);
		bus_rd(ADDR_OFFSET_CAL, OFFS_OTP);
		bus_rd(ADDR_RANGE_CONTROL, RANGE_OTP);
		check(d_addr === I2C_ADDR_LOW, "power-up address wrong");
		bus_wr(ADDR_MODE_CONTROL, 8'h88);
		check(d_trig === 1'b1 && d_hb === 1'b1, "trigger or heartbeat missing");
		@(posedge i_clk);
		check(d_trig === 1'b0, "trigger pulse too long");
		repeat (40) @(posedge i_clk);
		bus_wr(ADDR_MODE_CONTROL, VAL_STANDBY);
		bus_rd(ADDR_FIFO_LEVEL, 8'(mlvl));
		bus_rd(ADDR_X_SAMPLE_OUT, mx[FIFO_WIDTH-1:FIFO_WIDTH-8]);
		bus_rd(ADDR_Y_SAMPLE_OUT, my[FIFO_WIDTH-1:FIFO_WIDTH-8]);
		bus_rd(ADDR_Z_SAMPLE_OUT, mz[FIFO_WIDTH-1:FIFO_WIDTH-8]);
		bus_wr(ADDR_INIT_SETTING_A, v[7:0]);
		bus_wr(ADDR_RANGE_CONTROL, v[15:8]);
		bus_wr(ADDR_FIFO_WATERMARK, v[23:16]);
		check(d_range === v[15:8], "range output differs");
		bus_rd(ADDR_FIFO_WATERMARK, v[23:16]);
		lnk2.addr_strap_pin <= 1'b1;
		bus_wr(ADDR_RESET_RELOAD_COMMAND, 8'h80);
		check(d_busy === 1'b1, "reload not started");
		repeat (W + 2) @(posedge i_clk);
		bus_rd(ADDR_INIT_SETTING_A, v[7:0]);
		bus_rd(ADDR_FIFO_WATERMARK, v[23:16]);
		bus_rd(ADDR_RANGE_CONTROL, RANGE_OTP);
		bus_rd(ADDR_FIFO_LEVEL, 8'(mlvl));
		check(d_addr === I2C_ADDR_HIGH, "strap not resampled after reload");
		lnk2.addr_strap_pin <= 1'b0;
		bus_wr(ADDR_RESET_RELOAD_COMMAND, VAL_RESET_CMD);
		repeat (W + 2) @(posedge i_clk);
		bus_wr(ADDR_MODE_CONTROL, VAL_STANDBY);
		bus_rd(ADDR_FIFO_LEVEL, 8'(mlvl));
		bus_rd(ADDR_INIT_SETTING_A, 8'h00);
		bus_rd(ADDR_FIFO_WATERMARK, 8'h00);
		bus_rd(ADDR_GAIN_CAL, GAIN_OTP);
		check(d_addr === I2C_ADDR_LOW, "strap not resampled after reset");
		lnk2.spi_select_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		check(d_spi === 1'b1, "select low did not choose SPI");
		lnk2.spi_select_n <= 1'b1;
		bus_wr(ADDR_INTERFACE_SELECT, VAL_SEL_I2C);
		check(d_spi === 1'b0, "I2C select ignored");
		bus_rd(ADDR_STATUS, {I2C_ADDR_LOW, 1'b0});
		bus_rd(8'hFF, 8'h00);
	endtask
	task automatic run(input logic spi, input logic st);
		int k;
		@(posedge i_clk);
		obs.delete();
		busy_n = 0;
		use_spi <= spi;
		strap <= st;
		start <= 1'b1;
		@(posedge i_clk);
		start <= 1'b0;
		repeat (3) @(posedge i_clk);
		check(h_busy === 1'b1, "host idle during sequence");
		k = 0;
		while (done !== 1'b1 && k < 400) begin
			@(posedge i_clk);
			k++;
		end
		check(k < 400, "host sequence hung");
		if (k >= 400) results();
		#1;
		exp_w = '{16'h1001, 16'h2440, spi ? 16'h0D80 : 16'h0D40, 16'h0F42,
			16'h2001, 16'h2180, 16'h2800, 16'h1A00};
		check(obs.size() == 8, "wrong number of writes");
		for (int i = 0; i < 8; i++) begin
			check(obs.size() > i && obs[i] === exp_w[i], "write sequence differs");
		end
		check(gap > W, "select written inside reset wait");
		check(busy_n == W, "reset wait length differs");
		check(i2c_addr === (st ? I2C_ADDR_HIGH : I2C_ADDR_LOW), "strap address wrong");
		check(spi_mode === spi, "interface mode wrong");
		check(h_busy === 1'b0, "host busy after sequence");
	endtask
	// =====================================================
	// Main sequence
	initial begin
		lnk2.wr <= 1'b0;
		lnk2.rd <= 1'b0;
		lnk2.addr <= 8'h00;
		lnk2.wdata <= 8'h00;
		lnk2.spi_select_n <= 1'b1;
		lnk2.addr_strap_pin <= 1'b0;
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1'b1;
		direct();
		for (int i = 0; i < 4; i++) begin
			run(i[1], i[0]);
		end
		// A reset in the middle of a sequence must leave a clean restart.
		@(posedge i_clk);
		start <= 1'b1;
		@(posedge i_clk);
		start <= 1'b0;
		repeat (10) @(posedge i_clk);
		i_rst_n <= 1'b0;
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1'b1;
		run(1'b0, 1'b1);
		run(1'b1, 1'b0);
		results();
	end
endmodule
